// file: port_power_cfg.svh
/*
  timing and reset constants for the port power and over-current block.
  assumes a 20 MHz core clock; included by bare name.
*/
`ifndef PORT_POWER_CFG_SVH
`define PORT_POWER_CFG_SVH

`define CLK_FREQ_HZ        20000000
`define OCS_SINGLE_MS      5
`define OCS_DOUBLE_MS      20
// least time rounds up, longest time rounds down
`define OCS_SINGLE_CYC     ((`OCS_SINGLE_MS * `CLK_FREQ_HZ + 999) / 1000)
`define OCS_DOUBLE_CYC     ((`OCS_DOUBLE_MS * `CLK_FREQ_HZ) / 1000)
`define OC_FLAG_RESET      1'b0

`endif

// file: port_power_pkg.sv
/*
  types shared by the port power block.
  assumes nothing of its surroundings.
*/
package port_power_pkg;
  typedef enum logic [1:0] {
    OC_IDLE,
    OC_LOW1,
    OC_GAP,
    OC_LOW2
  } oc_state_t;
endpackage

// file: oc_detect.sv
/*
  over-current filter for one sense input.
  assumes sense_in is synchronous to ref_clk and meaningful only while powered.
*/
`timescale 1ns/1ns
`include "port_power_cfg.svh"

module oc_detect #(
  parameter int SINGLE_CYC = `OCS_SINGLE_CYC,
  parameter int DOUBLE_CYC = `OCS_DOUBLE_CYC
) (
  input  wire logic ref_clk,   // core clock
  input  wire logic reset,     // sync reset, active high
  input  wire logic powered,   // port power is on
  input  wire logic sense_in,  // sampled pin level
  output logic      oc_event   // one-cycle over-current pulse
);

  // ==========================================================
  // filter state
  port_power_pkg::oc_state_t state_ff;
  logic [31:0]               low_cnt_ff;
  logic [31:0]               win_cnt_ff;
  logic                      is_low;

  assign is_low = powered && !sense_in;

  always_ff @(posedge ref_clk)
  begin
    if (reset || !powered)
    begin
      state_ff   <= port_power_pkg::OC_IDLE;
      low_cnt_ff <= 32'h0;
      win_cnt_ff <= 32'h0;
    end
    else
    begin
      unique case (state_ff)
        port_power_pkg::OC_IDLE:
          if (is_low)
          begin
            state_ff   <= port_power_pkg::OC_LOW1;
            low_cnt_ff <= 32'h1;
            win_cnt_ff <= 32'h1;
          end
        port_power_pkg::OC_LOW1:
        begin
          win_cnt_ff <= win_cnt_ff + 32'h1;
          if (is_low)
            low_cnt_ff <= low_cnt_ff + 32'h1;
          else
            state_ff <= port_power_pkg::OC_GAP;
          // event fires below; restart after it
          if (is_low && low_cnt_ff + 32'h1 >= 32'(SINGLE_CYC))
            state_ff <= port_power_pkg::OC_IDLE;
        end
        port_power_pkg::OC_GAP:
        begin
          win_cnt_ff <= win_cnt_ff + 32'h1;
          // window expired: this low opens a fresh window at once, so no sample is lost
          if (win_cnt_ff >= 32'(DOUBLE_CYC) && is_low)
          begin
            state_ff   <= port_power_pkg::OC_LOW1;
            low_cnt_ff <= 32'h1;
            win_cnt_ff <= 32'h1;
          end
          else if (win_cnt_ff >= 32'(DOUBLE_CYC) || is_low)
            state_ff <= port_power_pkg::OC_IDLE;
        end
        port_power_pkg::OC_LOW2:
          state_ff <= port_power_pkg::OC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // event decode
  always_comb
  begin
    oc_event = 1'b0;
    if (!reset && powered)
    begin
      if (state_ff == port_power_pkg::OC_LOW1 && is_low
          && low_cnt_ff + 32'h1 >= 32'(SINGLE_CYC))
        oc_event = 1'b1;
      if (state_ff == port_power_pkg::OC_GAP && is_low
          && win_cnt_ff < 32'(DOUBLE_CYC))
        oc_event = 1'b1;
    end
  end

endmodule

// file: port_power_overcurrent_ctrl.sv
/*
  downstream port power control and over-current sensing, one shared
  open-drain pin per port, optional ganged mode on one pin.
  assumes sense inputs are synchronous to ref_clk and the pad resolves
  the pin from out/oe with the pull-up enabled when oe is low.
*/
// Operation
// - each port has one pin that is both power enable and over-current sense, for switch or fuse.
// - a port with power off has its pin driven low.
// - outside ganged mode, a port with power on releases its pin and enables the pull-up, an open-drain high.
// - a sense low lasting at least 5 ms while powered is an over-current.
// - two low groupings inside a window of at most 20 ms are an over-current.
// - a low caused by an opened poly fuse is an over-current just as with a switch.
// - outside ganged mode, a powered port has its sense input sampled continuously.
// - in ganged mode one shared pin controls power and senses over-current for all ports.
`timescale 1ns/1ns
`include "port_power_cfg.svh"

module port_power_overcurrent_ctrl #(
  parameter int NPORTS     = 2,
  parameter int SINGLE_CYC = `OCS_SINGLE_CYC,
  parameter int DOUBLE_CYC = `OCS_DOUBLE_CYC
) (
  input  wire logic              ref_clk,                   // core clock
  input  wire logic              reset,                     // sync reset, active high
  input  wire logic              gang_mode,                 // one shared pin for all ports
  input  wire logic [NPORTS-1:0] port_power_on,             // power request per port
  input  wire logic [NPORTS-1:0] oc_clear,                  // clear over-current flag
  input  wire logic [NPORTS-1:0] port_power_sense_pin_in,   // pin level per port
  output logic      [NPORTS-1:0] port_power_sense_pin_out,  // pin drive value
  output logic      [NPORTS-1:0] port_power_sense_pin_oe,   // pin drive enable
  output logic      [NPORTS-1:0] port_pullup_en,            // pull-up enable
  input  wire logic              shared_power_sense_pin_in, // shared pin level
  output logic                   shared_power_sense_pin_out,// shared pin drive value
  output logic                   shared_power_sense_pin_oe, // shared pin drive enable
  output logic                   shared_pullup_en,          // shared pull-up enable
  output logic      [NPORTS-1:0] oc_flag_ff                 // latched over-current
);

  // ==========================================================
  // pin drive
  logic [NPORTS-1:0] pwr_ff;
  logic              gang_ff;
  logic              shared_power_sense_pin;
  logic [NPORTS-1:0] oc_evt;
  logic              gang_evt;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pwr_ff  <= '0;
      gang_ff <= 1'b0;
    end
    else
    begin
      pwr_ff  <= port_power_on;
      gang_ff <= gang_mode;
    end
  end

  // ganged power is on only if any port asks for it
  assign shared_power_sense_pin = gang_ff && |pwr_ff;

  always_comb
  begin
    port_power_sense_pin_out   = '0;
    shared_power_sense_pin_out = 1'b0;
    // unused per-port pins in ganged mode stay driven low
    port_power_sense_pin_oe    = gang_ff ? '1 : ~pwr_ff;
    port_pullup_en             = gang_ff ? '0 : pwr_ff;
    shared_power_sense_pin_oe  = !shared_power_sense_pin;
    shared_pullup_en           = shared_power_sense_pin;
  end

  // ==========================================================
  // over-current filters; a fuse opening reads as a low like a switch
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : g_port
      oc_detect #(
        .SINGLE_CYC (SINGLE_CYC),
        .DOUBLE_CYC (DOUBLE_CYC)
      ) u_det (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .powered  (pwr_ff[g] && !gang_ff),
        .sense_in (port_power_sense_pin_in[g]),
        .oc_event (oc_evt[g])
      );
    end
  endgenerate

  oc_detect #(
    .SINGLE_CYC (SINGLE_CYC),
    .DOUBLE_CYC (DOUBLE_CYC)
  ) u_gang_det (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .powered  (shared_power_sense_pin),
    .sense_in (shared_power_sense_pin_in),
    .oc_event (gang_evt)
  );

  // ==========================================================
  // sticky flags; set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      oc_flag_ff <= {NPORTS{`OC_FLAG_RESET}};
    else
      oc_flag_ff <= (oc_flag_ff & ~oc_clear) | oc_evt
                    | {NPORTS{gang_evt}};
  end

endmodule

// file: ppo_assertions.sv
/* port power checker; sees the top ports only, bound to every instance */
`timescale 1ns/1ns
module ppo_checker #(
  parameter int NPORTS = 2
) (
  input wire logic              ref_clk,                   // clock
  input wire logic              reset,                     // reset
  input wire logic              gang_mode,                 // gang
  input wire logic [NPORTS-1:0] port_power_on,             // request
  input wire logic [NPORTS-1:0] oc_clear,                  // clear
  input wire logic [NPORTS-1:0] port_power_sense_pin_in,   // pin
  input wire logic [NPORTS-1:0] port_power_sense_pin_out,  // drive
  input wire logic [NPORTS-1:0] port_power_sense_pin_oe,   // enable
  input wire logic [NPORTS-1:0] port_pullup_en,            // pull-up
  input wire logic              shared_power_sense_pin_in, // pin
  input wire logic              shared_power_sense_pin_oe, // enable
  input wire logic              shared_pullup_en,          // pull-up
  input wire logic [NPORTS-1:0] oc_flag_ff                 // flags
);
  // ==========================================
  // checks, port 0 stands for all
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_pin_low: assert property (port_power_sense_pin_out == '0)
    else $error("drive not low");
  chk_off_drive: assert property (port_power_sense_pin_oe ==
    ($past(gang_mode) ? '1 : ~$past(port_power_on))) else $error("bad oe");
  chk_pullup_follow: assert property (port_pullup_en ==
    ($past(gang_mode) ? '0 : $past(port_power_on))) else $error("bad pull-up");
  chk_shared_oe: assert property (shared_power_sense_pin_oe ==
    !($past(gang_mode) && |$past(port_power_on))) else $error("bad shared oe");
  chk_shared_pull: assert property (shared_pullup_en == !shared_power_sense_pin_oe)
    else $error("bad shared pull-up");
  chk_single_low: assert property ((port_pullup_en[0] && !port_power_sense_pin_in[0]) [*5]
    |=> oc_flag_ff[0]) else $error("long low missed");
  chk_flag_hold: assert property (oc_flag_ff[0] && !oc_clear[0] |=> oc_flag_ff[0])
    else $error("flag lost");
  chk_flag_clear: assert property (oc_clear[0]
    && (port_power_sense_pin_in[0] || !port_pullup_en[0])
    && (shared_power_sense_pin_in || !shared_pullup_en) |=> !oc_flag_ff[0])
    else $error("flag not cleared");
endmodule
bind port_power_overcurrent_ctrl ppo_checker #(.NPORTS(NPORTS)) u_ppo_checker (.*);

// file: power_switch_model.sv
/* external switch or poly fuse at one pin; assumes hub pull-up on die */
`timescale 1ns/1ns
module power_switch_model (
  input  wire logic oe,      // hub drives low
  input  wire logic pull_en, // hub pull-up
  input  wire logic trip,    // fault or fuse open
  output logic      pin      // pin level
);
  // open-drain: any low wins over the pull-up; fuse build has no power-on-to-good wait
  assign pin = (oe || trip) ? 1'b0 : pull_en;
endmodule

// file: testbench.sv
/* bench for port power block; assumes a switch model at every pin */
`timescale 1ns/1ns
module testbench;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  logic       gang_mode = 1'b0;
  logic [1:0] port_power_on = 2'h0;
  logic [1:0] oc_clear = 2'h0;
  logic [2:0] trip = 3'h0;
  wire  [1:0] port_power_sense_pin_in;
  logic [1:0] port_power_sense_pin_out, port_power_sense_pin_oe;
  logic [1:0] port_pullup_en, oc_flag_ff;
  logic       shared_power_sense_pin_in, shared_power_sense_pin_out;
  logic       shared_power_sense_pin_oe, shared_pullup_en;
  int         mismatches = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  always #25 ref_clk = ~ref_clk;
  port_power_overcurrent_ctrl #(.NPORTS(2), .SINGLE_CYC(5), .DOUBLE_CYC(20))
    u_port_power_overcurrent_ctrl (.*);
  for (genvar i = 0; i < 2; i++)
  begin : g_sw
    power_switch_model u_sw (.oe(port_power_sense_pin_oe[i]), .pull_en(port_pullup_en[i]),
      .trip(trip[i]), .pin(port_power_sense_pin_in[i]));
  end
  power_switch_model u_sw_sh (.oe(shared_power_sense_pin_oe), .pull_en(shared_pullup_en),
    .trip(trip[2]), .pin(shared_power_sense_pin_in));
  // ==========================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // drivers end on a falling edge so checks read settled outputs
  task automatic pwr(input logic [1:0] v);
    @(posedge ref_clk) port_power_on <= v;
    cyc(2);
    @(negedge ref_clk);
  endtask
  // n low samples, the flag landing on the edge of the last one, then two more edges
  task automatic low(input int p, input int n);
    @(posedge ref_clk) trip[p] <= 1'b1;
    cyc(n);
    trip[p] <= 1'b0;
    cyc(2);
    @(negedge ref_clk);
  endtask
  task automatic clr;
    @(posedge ref_clk) oc_clear <= 2'h3;
    @(posedge ref_clk) oc_clear <= 2'h0;
    @(negedge ref_clk);
    chk(oc_flag_ff, 2'h0);
  endtask
  task automatic t_single;
    pwr(2'h3);
    chk(port_power_sense_pin_oe, 2'h0);
    chk(port_pullup_en, 2'h3);
    low(0, 4);
    chk(oc_flag_ff, 2'h0);
    // power off must also flush the half-built filter
    pwr(2'h2);
    chk(port_power_sense_pin_oe, 2'h1);
    pwr(2'h3);
    // an unflushed window would pair this lone low with the earlier group
    low(0, 1);
    chk(oc_flag_ff, 2'h0);
    cyc(20);
    low(0, 5);
    chk(oc_flag_ff, 2'h1);
    cyc(5);
    @(negedge ref_clk);
    chk(oc_flag_ff, 2'h1);
    clr();
    $display("test single done");
  endtask
  task automatic t_double;
    low(0, 2);
    cyc(1);
    low(0, 1);
    chk(oc_flag_ff, 2'h1);
    clr();
    // two groups further apart than the window are no over-current
    low(0, 1);
    cyc(20);
    low(0, 1);
    chk(oc_flag_ff, 2'h0);
    pwr(2'h1);
    low(1, 8);
    chk(oc_flag_ff, 2'h0);
    $display("test double done");
  endtask
  task automatic t_gang;
    @(posedge ref_clk) gang_mode <= 1'b1;
    pwr(2'h3);
    chk(port_power_sense_pin_oe, 2'h3);
    chk({shared_power_sense_pin_oe, shared_pullup_en}, 2'h1);
    chk({shared_power_sense_pin_out, 1'b0}, 2'h0);
    low(2, 5);
    chk(oc_flag_ff, 2'h3);
    clr();
    $display("test gang done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk(port_power_sense_pin_oe, 2'h3);
    t_single();
    t_double();
    t_gang();
    complete_run();
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      complete_run();
    end
  end
endmodule
